// ===== hw/pce_regs.svh
`ifndef PCE_REGS_SVH
`define PCE_REGS_SVH
`define PCE_EV_CLK        8'h3c
`define PCE_EV_ICACHE     8'h80
`define PCE_EV_OFFCORE    8'hb7
`define PCE_EV_INST       8'hc0
`define PCE_EV_UOPS       8'hc2
`define PCE_EV_CLEAR      8'hc3
`define PCE_EV_BR         8'hc4
`define PCE_EV_MISP       8'hc5
`define PCE_UM_00         8'h00
`define PCE_UM_01         8'h01
`define PCE_UM_02         8'h02
`define PCE_UM_03         8'h03
`define PCE_UM_04         8'h04
`define PCE_UM_08         8'h08
`define PCE_UM_10         8'h10
`define PCE_UM_7E         8'h7e
`define PCE_UM_BF         8'hbf
`define PCE_UM_EB         8'heb
`define PCE_UM_F7         8'hf7
`define PCE_UM_F9         8'hf9
`define PCE_UM_FB         8'hfb
`define PCE_UM_FD         8'hfd
`define PCE_UM_FE         8'hfe
`define PCE_CNT_RESET     48'h000000000000
`define PCE_FILT_RESET    16'h0000
`endif

// ===== hw/pce_pkg.sv
package pce_pkg;
    typedef enum logic [3:0] {
        PCE_BR_NONE,
        PCE_BR_COND,
        PCE_BR_FAR,
        PCE_BR_NEAR_IND_JMP,
        PCE_BR_NEAR_IND_CALL,
        PCE_BR_NEAR_REL_CALL,
        PCE_BR_NEAR_RETURN,
        PCE_BR_NEAR_REL_JMP
    } pce_branch_type;
    typedef enum logic [1:0] {
        PCE_FT_IDLE,
        PCE_FT_MISS_PENDING
    } pce_fetch_state_type;
endpackage : pce_pkg

// ===== hw/pce_counter.sv
`timescale 1ns/100ps
`include "pce_regs.svh"
module pce_counter
    import pce_pkg::*;
#(
    parameter int WIDTH = 48
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    input  wire logic             i_clear,
    input  wire logic [3:0]       i_inc,
    output logic      [WIDTH-1:0] o_count
);
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || i_clear) begin
            o_count <= WIDTH'(`PCE_CNT_RESET);
        end else begin
            o_count <= o_count + WIDTH'(i_inc);
        end
    end
endmodule : pce_counter

// ===== hw/pce_fetch_tracker.sv
`timescale 1ns/100ps
`include "pce_regs.svh"
module pce_fetch_tracker
    import pce_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_fetch_valid,
    input  wire logic i_fetch_hit,
    input  wire logic i_fetch_uncacheable,
    input  wire logic i_miss_return,
    output logic      o_fetch_hit,
    output logic      o_fetch_any,
    output logic      o_fetch_miss
);
    pce_fetch_state_type state;
    pce_fetch_state_type next_state;
    logic                new_miss;

    // a miss stays outstanding until its fill; only its first cycle counts
    assign new_miss = i_fetch_valid && (!i_fetch_hit || i_fetch_uncacheable)
                      && (state == PCE_FT_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            PCE_FT_IDLE:         if (new_miss) next_state = PCE_FT_MISS_PENDING;
            PCE_FT_MISS_PENDING: if (i_miss_return) next_state = PCE_FT_IDLE;
            default:             next_state = PCE_FT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) state <= PCE_FT_IDLE;
        else state <= next_state;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_fetch_hit  <= 1'b0;
            o_fetch_any  <= 1'b0;
            o_fetch_miss <= 1'b0;
        end else begin
            o_fetch_hit  <= i_fetch_valid && i_fetch_hit && !i_fetch_uncacheable;
            o_fetch_any  <= i_fetch_valid && state == PCE_FT_IDLE;
            o_fetch_miss <= new_miss;
        end
    end
endmodule : pce_fetch_tracker

// ===== hw/pce_event_core.sv
`timescale 1ns/100ps
`include "pce_regs.svh"
module pce_event_core
    import pce_pkg::*;
#(
    parameter int WIDTH    = 48,
    parameter int NUM_PROG = 2
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_halted,
    input  wire logic                     i_ref_tick,
    input  wire logic                     i_fetch_valid,
    input  wire logic                     i_fetch_hit,
    input  wire logic                     i_fetch_uncacheable,
    input  wire logic                     i_miss_return,
    input  wire logic                     i_offcore_valid,
    input  wire logic [15:0]              i_offcore_attr,
    input  wire logic [1:0]               i_instr_retired,
    input  wire logic [1:0]               i_uops_retired,
    input  wire logic [1:0]               i_uops_rom_retired,
    input  wire logic                     i_clear_smc,
    input  wire logic                     i_clear_order,
    input  wire logic                     i_clear_fp,
    input  wire logic                     i_clear_other,
    input  wire logic                     i_branch_retired,
    input  wire pce_branch_type           i_branch_type,
    input  wire logic                     i_branch_pred_taken,
    input  wire logic                     i_branch_mispredicted,
    input  wire logic [NUM_PROG*8-1:0]    i_event_code,
    input  wire logic [NUM_PROG*8-1:0]    i_unit_mask,
    input  wire logic [15:0]              i_offcore_filter_a,
    input  wire logic [15:0]              i_offcore_filter_b,
    input  wire logic [NUM_PROG-1:0]      i_prog_clear,
    input  wire logic [2:0]               i_fixed_clear,
    output logic      [NUM_PROG*WIDTH-1:0] o_prog_count,
    output logic      [WIDTH-1:0]         o_instr_retired_fixed,
    output logic      [WIDTH-1:0]         o_unhalted_core_cycles_fixed,
    output logic      [WIDTH-1:0]         o_unhalted_ref_cycles_fixed
);
    logic fetch_hit;
    logic fetch_any;
    logic fetch_miss;
    logic unhalted_core;
    logic unhalted_ref;
    logic match_a;
    logic match_b;
    logic any_clear;
    logic br_cond;
    logic br_ind;
    logic br_call;

    pce_fetch_tracker u_fetch (
        .i_clk_sys           (i_clk_sys),
        .i_reset_n           (i_reset_n),
        .i_fetch_valid       (i_fetch_valid),
        .i_fetch_hit         (i_fetch_hit),
        .i_fetch_uncacheable (i_fetch_uncacheable),
        .i_miss_return       (i_miss_return),
        .o_fetch_hit         (fetch_hit),
        .o_fetch_any         (fetch_any),
        .o_fetch_miss        (fetch_miss)
    );

    assign unhalted_core = !i_halted;
    // ref tick comes from a fixed-rate source, so frequency scaling never shows
    assign unhalted_ref  = i_ref_tick && !i_halted;
    // filter bits: request type in low byte, response in high; a match needs overlap in both bytes
    assign match_a = i_offcore_valid
                     && |(i_offcore_attr[7:0] & i_offcore_filter_a[7:0])
                     && |(i_offcore_attr[15:8] & i_offcore_filter_a[15:8]);
    assign match_b = i_offcore_valid
                     && |(i_offcore_attr[7:0] & i_offcore_filter_b[7:0])
                     && |(i_offcore_attr[15:8] & i_offcore_filter_b[15:8]);
    // interrupts and faults also clear, so the total exceeds the three causes
    assign any_clear = i_clear_smc || i_clear_order || i_clear_fp || i_clear_other;
    assign br_cond = i_branch_retired && i_branch_type == PCE_BR_COND;
    assign br_ind  = i_branch_retired && (i_branch_type == PCE_BR_NEAR_IND_JMP
                     || i_branch_type == PCE_BR_NEAR_IND_CALL);
    assign br_call = i_branch_retired && (i_branch_type == PCE_BR_NEAR_IND_CALL
                     || i_branch_type == PCE_BR_NEAR_REL_CALL);

    function automatic logic [3:0] select_event(input logic [7:0] code,
                                                input logic [7:0] mask);
        logic [3:0] inc;
        inc = 4'h0;
        case (code)
            `PCE_EV_CLK: begin
                if (mask == `PCE_UM_00) inc = {3'h0, unhalted_core};
                else if (mask == `PCE_UM_01) inc = {3'h0, unhalted_ref};
            end
            `PCE_EV_ICACHE: begin
                if (mask == `PCE_UM_01) inc = {3'h0, fetch_hit};
                else if (mask == `PCE_UM_02) inc = {3'h0, fetch_miss};
                else if (mask == `PCE_UM_03) inc = {3'h0, fetch_any};
            end
            `PCE_EV_OFFCORE: begin
                if (mask == `PCE_UM_01) inc = {3'h0, match_a};
                else if (mask == `PCE_UM_02) inc = {3'h0, match_b};
            end
            `PCE_EV_INST: begin
                if (mask == `PCE_UM_00) inc = {2'h0, i_instr_retired};
            end
            `PCE_EV_UOPS: begin
                if (mask == `PCE_UM_01) inc = {2'h0, i_uops_rom_retired};
                else if (mask == `PCE_UM_10) inc = {2'h0, i_uops_retired};
            end
            `PCE_EV_CLEAR: begin
                case (mask)
                    `PCE_UM_01: inc = {3'h0, i_clear_smc};
                    `PCE_UM_02: inc = {3'h0, i_clear_order};
                    `PCE_UM_04: inc = {3'h0, i_clear_fp};
                    `PCE_UM_08: inc = {3'h0, any_clear};
                    default:    inc = 4'h0;
                endcase
            end
            `PCE_EV_BR: begin
                case (mask)
                    `PCE_UM_00: inc = {3'h0, i_branch_retired};
                    `PCE_UM_7E: inc = {3'h0, br_cond};
                    `PCE_UM_BF: inc = {3'h0, i_branch_retired
                                       && i_branch_type == PCE_BR_FAR};
                    `PCE_UM_EB: inc = {3'h0, br_ind};
                    `PCE_UM_F7: inc = {3'h0, i_branch_retired
                                       && i_branch_type == PCE_BR_NEAR_RETURN};
                    `PCE_UM_F9: inc = {3'h0, br_call};
                    `PCE_UM_FB: inc = {3'h0, i_branch_retired
                                       && i_branch_type == PCE_BR_NEAR_IND_CALL};
                    `PCE_UM_FD: inc = {3'h0, i_branch_retired
                                       && i_branch_type == PCE_BR_NEAR_REL_CALL};
                    `PCE_UM_FE: inc = {3'h0, br_cond && i_branch_pred_taken};
                    default:    inc = 4'h0;
                endcase
            end
            `PCE_EV_MISP: begin
                if (mask == `PCE_UM_00)
                    inc = {3'h0, i_branch_retired && i_branch_mispredicted};
            end
            default: inc = 4'h0;
        endcase
        return inc;
    endfunction : select_event

    genvar g;
    generate
        for (g = 0; g < NUM_PROG; g++) begin : g_prog
            logic [3:0] inc;
            // a plain assign would miss pulses that are read only inside the function
            always_comb begin
                inc = select_event(i_event_code[g*8 +: 8], i_unit_mask[g*8 +: 8]);
            end
            pce_counter #(.WIDTH(WIDTH)) u_cnt (
                .i_clk_sys (i_clk_sys),
                .i_reset_n (i_reset_n),
                .i_clear   (i_prog_clear[g]),
                .i_inc     (inc),
                .o_count   (o_prog_count[g*WIDTH +: WIDTH])
            );
        end
    endgenerate

    // fixed counters need no selection and mirror the programmable conditions
    pce_counter #(.WIDTH(WIDTH)) u_fix0 (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_clear   (i_fixed_clear[0]),
        .i_inc     ({2'h0, i_instr_retired}),
        .o_count   (o_instr_retired_fixed)
    );
    pce_counter #(.WIDTH(WIDTH)) u_fix1 (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_clear   (i_fixed_clear[1]),
        .i_inc     ({3'h0, unhalted_core}),
        .o_count   (o_unhalted_core_cycles_fixed)
    );
    pce_counter #(.WIDTH(WIDTH)) u_fix2 (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_clear   (i_fixed_clear[2]),
        .i_inc     ({3'h0, unhalted_ref}),
        .o_count   (o_unhalted_ref_cycles_fixed)
    );

    // watch counter zero; the bench walks it through every listed pair
    logic             live0;
    logic [15:0]      pair0;
    logic [WIDTH-1:0] cnt0;
    pce_branch_type   ret_kind;
    assign live0    = i_reset_n && !i_prog_clear[0];
    assign pair0    = {i_event_code[7:0], i_unit_mask[7:0]};
    assign cnt0     = o_prog_count[WIDTH-1:0];
    assign ret_kind = i_branch_retired ? i_branch_type : PCE_BR_NONE;

    // selected pair adds what the pipeline reported one edge earlier
    property p_adds(logic picked, logic [1:0] amount);
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        live0 && picked |=> cnt0 == $past(cnt0) + WIDTH'($past(amount));
    endproperty

    a_halt_stops_core: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_halted && !i_fixed_clear[1] |=> $stable(o_unhalted_core_cycles_fixed))
        else $error("core cycles advanced while halted");
    a_run_adds_core: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !i_halted && !i_fixed_clear[1] |=>
        o_unhalted_core_cycles_fixed == $past(o_unhalted_core_cycles_fixed) + 1)
        else $error("core cycles missed a running cycle");
    a_ref_gated: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_fixed_clear[2] && !(i_ref_tick && !i_halted) |=>
        $stable(o_unhalted_ref_cycles_fixed))
        else $error("ref cycles moved without a tick");
    a_ref_adds: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !i_fixed_clear[2] && i_ref_tick && !i_halted |=>
        o_unhalted_ref_cycles_fixed == $past(o_unhalted_ref_cycles_fixed) + 1)
        else $error("ref cycles missed a tick");
    a_instr_adds: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !i_fixed_clear[0] |=> o_instr_retired_fixed ==
        $past(o_instr_retired_fixed) + WIDTH'($past(i_instr_retired)))
        else $error("fixed instruction count wrong");
    a_fixed_clears: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_fixed_clear[0] |=> o_instr_retired_fixed == '0)
        else $error("fixed counter did not clear");
    a_miss_once: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        fetch_miss |=> !fetch_miss)
        else $error("miss counted twice");
    a_unlisted_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        live0 && (i_event_code[7:0] == 8'h00 || pair0 == {`PCE_EV_CLK, `PCE_UM_02}
                  || pair0 == {`PCE_EV_BR, `PCE_UM_01}) |=>
        $stable(cnt0))
        else $error("unlisted event counted");
    // a fetch miss surfaces as a pulse first and is added on the edge after it
    sequence s_miss_sel;
        live0 && pair0 == {`PCE_EV_ICACHE, `PCE_UM_02};
    endsequence
    sequence s_miss_added;
        cnt0 == $past(cnt0) + WIDTH'($past(fetch_miss));
    endsequence
    a_pc_miss: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        s_miss_sel |=> s_miss_added)
        else $error("fetch miss count wrong");
    a_pc_core: assert property (
        p_adds(pair0 == {`PCE_EV_CLK, `PCE_UM_00}, !i_halted))
        else $error("core cycle event wrong");
    a_pc_ref: assert property (
        p_adds(pair0 == {`PCE_EV_CLK, `PCE_UM_01}, i_ref_tick && !i_halted))
        else $error("reference cycle event wrong");
    a_pc_hit: assert property (
        p_adds(pair0 == {`PCE_EV_ICACHE, `PCE_UM_01}, fetch_hit))
        else $error("fetch hit event wrong");
    a_pc_access: assert property (
        p_adds(pair0 == {`PCE_EV_ICACHE, `PCE_UM_03}, fetch_any))
        else $error("fetch access event wrong");
    a_pc_instr: assert property (
        p_adds(pair0 == {`PCE_EV_INST, `PCE_UM_00}, i_instr_retired))
        else $error("retired instruction event wrong");
    a_pc_rom_uops: assert property (
        p_adds(pair0 == {`PCE_EV_UOPS, `PCE_UM_01}, i_uops_rom_retired))
        else $error("rom micro-op event wrong");
    a_pc_all_uops: assert property (
        p_adds(pair0 == {`PCE_EV_UOPS, `PCE_UM_10}, i_uops_retired))
        else $error("micro-op event wrong");
    a_pc_smc: assert property (
        p_adds(pair0 == {`PCE_EV_CLEAR, `PCE_UM_01}, i_clear_smc))
        else $error("code write clear event wrong");
    a_pc_order: assert property (
        p_adds(pair0 == {`PCE_EV_CLEAR, `PCE_UM_02}, i_clear_order))
        else $error("ordering clear event wrong");
    a_pc_assist: assert property (
        p_adds(pair0 == {`PCE_EV_CLEAR, `PCE_UM_04}, i_clear_fp))
        else $error("assist clear event wrong");
    a_pc_any_clear: assert property (
        p_adds(pair0 == {`PCE_EV_CLEAR, `PCE_UM_08},
               i_clear_smc || i_clear_order || i_clear_fp || i_clear_other))
        else $error("any clear event wrong");
    a_pc_branches: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_00}, i_branch_retired))
        else $error("branch event wrong");
    a_pc_cond: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_7E}, ret_kind == PCE_BR_COND))
        else $error("conditional branch event wrong");
    a_pc_far: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_BF}, ret_kind == PCE_BR_FAR))
        else $error("far branch event wrong");
    a_pc_near_ind: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_EB},
               ret_kind == PCE_BR_NEAR_IND_JMP || ret_kind == PCE_BR_NEAR_IND_CALL))
        else $error("near indirect event wrong");
    a_pc_return: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_F7}, ret_kind == PCE_BR_NEAR_RETURN))
        else $error("near return event wrong");
    a_pc_calls: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_F9},
               ret_kind == PCE_BR_NEAR_IND_CALL || ret_kind == PCE_BR_NEAR_REL_CALL))
        else $error("near call event wrong");
    a_pc_ind_call: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_FB}, ret_kind == PCE_BR_NEAR_IND_CALL))
        else $error("indirect call event wrong");
    a_pc_rel_call: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_FD}, ret_kind == PCE_BR_NEAR_REL_CALL))
        else $error("relative call event wrong");
    a_pc_taken: assert property (
        p_adds(pair0 == {`PCE_EV_BR, `PCE_UM_FE},
               ret_kind == PCE_BR_COND && i_branch_pred_taken))
        else $error("predicted taken event wrong");
    a_pc_misp: assert property (
        p_adds(pair0 == {`PCE_EV_MISP, `PCE_UM_00}, i_branch_retired && i_branch_mispredicted))
        else $error("mispredicted branch event wrong");
endmodule : pce_event_core

// ===== dv/pce_core_model.sv
`timescale 1ns/100ps
module pce_core_model
    import pce_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_run,
    output logic      [38:0] o_ev
);
    logic [31:0] r1;
    logic [31:0] r2;
    logic [38:0] v;
    logic        pend = 1'b0;
    initial o_ev = '0;
    // random pipeline pulses; all lines low between bursts
    always @(posedge i_clk_sys) begin
        r1 = $urandom;
        r2 = $urandom;
        v = {r2[15:0], r1[22:0]};
        v[15:14] = v[15:14] & v[17:16];
        v[19:18] = v[19:18] & v[17:16];
        // one outstanding miss; return only while one is pending
        v[5] = v[5] & pend & !v[2];
        if (!i_run) begin
            v = '0;
        end
        o_ev <= v;
        if (v[2] && !pend && (!v[3] || v[4])) begin
            pend <= 1'b1;
        end else if (v[5]) begin
            pend <= 1'b0;
        end
    end
endmodule : pce_core_model

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb
    import pce_pkg::*;
;
    typedef struct {int k; logic [47:0] v;} pce_note_type;
    localparam logic [15:0] PT [26] = '{16'h3c00, 16'h3c01, 16'h8001, 16'h8002,
        16'h8003, 16'hb701, 16'hb702, 16'hc000, 16'hc201, 16'hc210, 16'hc301,
        16'hc302, 16'hc304, 16'hc308, 16'hc400, 16'hc47e, 16'hc4bf, 16'hc4eb,
        16'hc4f7, 16'hc4f9, 16'hc4fb, 16'hc4fd, 16'hc4fe, 16'hc500, 16'h3c02,
        16'hc401};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        run = 1'b0;
    logic        clr = 1'b0;
    logic [15:0] ec = '0;
    logic [15:0] um = '0;
    logic [15:0] fa = '0;
    logic [15:0] fb = '0;
    logic [38:0] ev;
    logic [95:0] pc;
    wire  [47:0] got [5];
    logic [47:0] acc [5] = '{default: '0};
    logic        pd = 1'b0;
    logic        mi;
    logic        ac;
    int          err_count = 0;
    int          comparisons = 0;
    pce_note_type nq [$];
    event        chk;
    always #20 clk = ~clk;
    pce_core_model u_core (.i_clk_sys(clk), .i_run(run), .o_ev(ev));
    pce_event_core u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_halted(ev[0]),
        .i_ref_tick(ev[1]), .i_fetch_valid(ev[2]), .i_fetch_hit(ev[3]),
        .i_fetch_uncacheable(ev[4]), .i_miss_return(ev[5]), .i_offcore_valid(ev[6]),
        .i_offcore_attr(ev[38:23]), .i_instr_retired(ev[15:14]),
        .i_uops_retired(ev[17:16]), .i_uops_rom_retired(ev[19:18]),
        .i_clear_smc(ev[7]), .i_clear_order(ev[8]), .i_clear_fp(ev[9]),
        .i_clear_other(ev[10]), .i_branch_retired(ev[11]),
        .i_branch_type(pce_branch_type'({1'b0, ev[22:20]})),
        .i_branch_pred_taken(ev[12]), .i_branch_mispredicted(ev[13]),
        .i_event_code(ec), .i_unit_mask(um), .i_offcore_filter_a(fa),
        .i_offcore_filter_b(fb), .i_prog_clear({2{clr}}), .i_fixed_clear({3{clr}}),
        .o_prog_count(pc), .o_instr_retired_fixed(got[2]),
        .o_unhalted_core_cycles_fixed(got[3]), .o_unhalted_ref_cycles_fixed(got[4]));
    assign got[0] = pc[47:0];
    assign got[1] = pc[95:48];
    // reference increment of one selector for the values at this edge
    function automatic int inc(input logic [15:0] p);
        logic [2:0] bt;
        bt = ev[22:20];
        case (p)
            16'h3c00: return !ev[0];
            16'h3c01: return !ev[0] & ev[1];
            16'h8001: return ev[2] & ev[3] & !ev[4];
            16'h8002: return mi;
            16'h8003: return ac;
            16'hb701: return ev[6] & |(ev[30:23] & fa[7:0]) & |(ev[38:31] & fa[15:8]);
            16'hb702: return ev[6] & |(ev[30:23] & fb[7:0]) & |(ev[38:31] & fb[15:8]);
            16'hc000: return ev[15:14];
            16'hc201: return ev[19:18];
            16'hc210: return ev[17:16];
            16'hc301: return ev[7];
            16'hc302: return ev[8];
            16'hc304: return ev[9];
            16'hc308: return |ev[10:7];
            16'hc400: return ev[11];
            16'hc47e: return ev[11] & (bt == 3'd1);
            16'hc4bf: return ev[11] & (bt == 3'd2);
            16'hc4eb: return ev[11] & (bt == 3'd3 || bt == 3'd4);
            16'hc4f7: return ev[11] & (bt == 3'd6);
            16'hc4f9: return ev[11] & (bt == 3'd4 || bt == 3'd5);
            16'hc4fb: return ev[11] & (bt == 3'd4);
            16'hc4fd: return ev[11] & (bt == 3'd5);
            16'hc4fe: return ev[11] & (bt == 3'd1) & ev[12];
            16'hc500: return ev[11] & ev[13];
            default: return 0;
        endcase
    endfunction : inc
    always @(posedge clk) begin
        if (rst_n) begin
            mi = 1'b0;
            ac = 1'b0;
            if (!pd) begin
                ac = ev[2];
                mi = ev[2] & (!ev[3] | ev[4]);
            end
            for (int g = 0; g < 2; g++) begin
                acc[g] <= clr ? '0 : acc[g] + 48'(inc({ec[g*8+:8], um[g*8+:8]}));
            end
            acc[2] <= clr ? '0 : acc[2] + 48'(ev[15:14]);
            acc[3] <= clr ? '0 : acc[3] + 48'(!ev[0]);
            acc[4] <= clr ? '0 : acc[4] + 48'(!ev[0] & ev[1]);
            if (mi) begin
                pd <= 1'b1;
            end else if (ev[5]) begin
                pd <= 1'b0;
            end
        end
    end
    always begin
        pce_note_type n;
        @(chk);
        while (nq.size() > 0) begin
            n = nq.pop_front();
            comparisons++;
            if (got[n.k] !== n.v) begin
                err_count++;
                $display("[ERR] %0t counter %0d got %h expected %h", $time, n.k, got[n.k], n.v);
            end
        end
    end
    // counts settle away from the edge; icache needs two edges
    task automatic check_all(input int t);
        repeat (4) @(posedge clk);
        @(negedge clk);
        for (int k = 0; k < 5; k++) begin
            nq.push_back('{k, acc[k]});
        end
        ->chk;
        // let the watcher drain the notes before anything moves on or ends the run
        wait (nq.size() == 0);
        $display("test %0d done", t);
    endtask : check_all
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h8457));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 26; i++) begin
            @(posedge clk);
            ec <= {PT[(i + 1) % 26][15:8], PT[i][15:8]};
            um <= {PT[(i + 1) % 26][7:0], PT[i][7:0]};
            fa <= 16'($urandom);
            fb <= 16'($urandom);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            run <= 1'b1;
            repeat (150) @(posedge clk);
            run <= 1'b0;
            check_all(i);
        end
        // clear held against live traffic restarts counts from zero; they must match the model
        @(posedge clk);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        clr <= 1'b1;
        repeat (3) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        clr <= 1'b0;
        check_all(26);
        tally_and_finish();
    end
endmodule : tb
